// [rtl/slrac_consts.vh]
`ifndef SLRAC_CONSTS_VH
`define SLRAC_CONSTS_VH
// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SLRAC_IDX_CTRL     10'h300
`define SLRAC_IDX_MEAS     10'h302
`define SLRAC_IDX_FIXED    10'h304
`define SLRAC_IDX_RELEASE  10'h306
`define SLRAC_IDX_XBAR_A   10'h308
`define SLRAC_IDX_XBAR_B   10'h309
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SLRAC_CTRL_CHK_BIT 6
`define SLRAC_CTRL_EN_BIT  0
`define SLRAC_XBAR_EVEN_LO 0
`define SLRAC_XBAR_ODD_LO  3
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SLRAC_RST_CTRL     8'h00
`define SLRAC_RST_CHK      1'b0
`define SLRAC_RST_EN       1'b0
`define SLRAC_RST_MEAS     5'h00
`define SLRAC_RST_FIXED    5'h00
`define SLRAC_RST_RELEASE  5'h1F
`define SLRAC_RST_XBAR_A   6'h08
`define SLRAC_RST_XBAR_B   6'h1A
// ----------------------------------------------------------------
// Timing and sizes
// ----------------------------------------------------------------
`define SLRAC_DELAY_MAX    5'h1F
`define SLRAC_RELEASE_MAX  5'h0A
`define SLRAC_LANE_W       8
`define SLRAC_NUM_OCT      13
`endif

// [rtl/slrac_top.v]
`include "slrac_consts.vh"
module slrac_top
(
  input  wire        i_clk,
  input  wire        i_rstn,
  // Wishbone classic slave
  input  wire        i_wb_cyc,
  input  wire        i_wb_stb,
  input  wire        i_wb_we,
  input  wire [11:0] i_wb_adr,
  input  wire [3:0]  i_wb_sel,
  input  wire [31:0] i_wb_dat,
  output reg  [31:0] o_wb_dat,
  output reg         o_wb_ack,
  // Link side, asynchronous to i_clk
  input  wire        i_pclk,
  input  wire        i_lmfc_global,
  input  wire        i_lmfc_local,
  // Deframer side, on i_clk
  input  wire [103:0] i_cfg_octets,
  input  wire [7:0]  i_cfg_chk,
  input  wire [63:0] i_phy_data,
  output reg  [31:0] o_lane_data,
  output reg  [7:0]  o_cfg_sum,
  output reg         o_cfg_chk_err,
  output wire        o_link_active,
  output reg         o_buf_release
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg        chk_mode_r;
  reg        link_en_r;
  reg  [4:0] meas_r;
  reg  [4:0] fixed_r;
  reg  [4:0] release_r;
  reg  [5:0] xbar_a_r;
  reg  [5:0] xbar_b_r;

  wire [9:0] idx;
  wire       req;
  wire       wr;
  reg  [7:0] rd_nxt;

  assign idx = i_wb_adr[11:2];
  // One answer per request; ack drops the cycle after it is given
  assign req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr  = req & i_wb_we & i_wb_sel[0];

  // Read mux; reserved bits and unmapped words read zero
  always @*
  begin
    rd_nxt = 8'h00;
    case (idx)
      `SLRAC_IDX_CTRL:
      begin
        rd_nxt[`SLRAC_CTRL_CHK_BIT] = chk_mode_r;
        rd_nxt[`SLRAC_CTRL_EN_BIT]  = link_en_r;
      end
      `SLRAC_IDX_MEAS:    rd_nxt = {3'h0, meas_r};
      `SLRAC_IDX_FIXED:   rd_nxt = {3'h0, fixed_r};
      `SLRAC_IDX_RELEASE: rd_nxt = {3'h0, release_r};
      `SLRAC_IDX_XBAR_A:  rd_nxt = {2'h0, xbar_a_r};
      `SLRAC_IDX_XBAR_B:  rd_nxt = {2'h0, xbar_b_r};
      default:            rd_nxt = 8'h00;
    endcase
  end

  // Bus answer: ack one cycle after the request, data from flip-flops
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end
    else
    begin
      o_wb_ack <= req;
      if (req)
        o_wb_dat <= {24'h000000, rd_nxt};
    end
  end

  // Writable fields; unmapped writes are acked and dropped
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      chk_mode_r <= `SLRAC_RST_CHK;
      link_en_r  <= `SLRAC_RST_EN;
      fixed_r    <= `SLRAC_RST_FIXED;
      release_r  <= `SLRAC_RST_RELEASE;
      xbar_a_r   <= `SLRAC_RST_XBAR_A;
      xbar_b_r   <= `SLRAC_RST_XBAR_B;
    end
    else if (wr)
    begin
      case (idx)
        `SLRAC_IDX_CTRL:
        begin
          chk_mode_r <= i_wb_dat[`SLRAC_CTRL_CHK_BIT];
          link_en_r  <= i_wb_dat[`SLRAC_CTRL_EN_BIT];
        end
        `SLRAC_IDX_FIXED:   fixed_r   <= i_wb_dat[4:0];
        `SLRAC_IDX_RELEASE: release_r <= i_wb_dat[4:0];
        `SLRAC_IDX_XBAR_A:  xbar_a_r  <= i_wb_dat[5:0];
        `SLRAC_IDX_XBAR_B:  xbar_b_r  <= i_wb_dat[5:0];
        default:            chk_mode_r <= chk_mode_r;
      endcase
    end
  end

  assign o_link_active = link_en_r;

  // ----------------------------------------------------------------
  // Link input synchronisers
  // ----------------------------------------------------------------
  reg  [1:0] pclk_s;
  reg  [1:0] glob_s;
  reg  [1:0] loc_s;
  reg        pclk_d;
  reg        glob_d;
  reg        loc_d;
  wire       tick;
  wire       glob_rise;
  wire       loc_rise;

  // Three flops per pin; edges come from the second and third stages
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pclk_s <= 2'h0;
      glob_s <= 2'h0;
      loc_s  <= 2'h0;
      pclk_d <= 1'b0;
      glob_d <= 1'b0;
      loc_d  <= 1'b0;
    end
    else
    begin
      pclk_s <= {pclk_s[0], i_pclk};
      glob_s <= {glob_s[0], i_lmfc_global};
      loc_s  <= {loc_s[0], i_lmfc_local};
      pclk_d <= pclk_s[1];
      glob_d <= glob_s[1];
      loc_d  <= loc_s[1];
    end
  end

  // Processing-clock rising edge is the one-cycle time unit
  assign tick      = pclk_s[1] & ~pclk_d;
  assign glob_rise = glob_s[1] & ~glob_d;
  assign loc_rise  = loc_s[1] & ~loc_d;

  // ----------------------------------------------------------------
  // Multiframe delay, latency measure and buffer release
  // ----------------------------------------------------------------
  localparam ST_IDLE  = 2'h0;
  localparam ST_DELAY = 2'h1;
  localparam ST_RUN   = 2'h2;

  reg [1:0] state_r;
  reg [4:0] dly_cnt_r;
  reg [4:0] mf_cnt_r;
  reg       meas_busy_r;

  // Global edge is held back by the fixed delay, then a multiframe
  // position counter runs; a new global edge during the count restarts the sequence.
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_r       <= ST_IDLE;
      dly_cnt_r     <= 5'h00;
      mf_cnt_r      <= 5'h00;
      meas_busy_r   <= 1'b0;
      meas_r        <= `SLRAC_RST_MEAS;
      o_buf_release <= 1'b0;
    end
    else if (!link_en_r)
    begin
      state_r       <= ST_IDLE;
      dly_cnt_r     <= 5'h00;
      mf_cnt_r      <= 5'h00;
      meas_busy_r   <= 1'b0;
      o_buf_release <= 1'b0;
    end
    else
    begin
      o_buf_release <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          if (glob_rise)
          begin
            dly_cnt_r <= 5'h00;
            state_r   <= ST_DELAY;
          end
        end
        ST_DELAY:
        begin
          if (dly_cnt_r == fixed_r)
          begin
            mf_cnt_r    <= 5'h00;
            meas_busy_r <= 1'b1;
            state_r     <= ST_RUN;
          end
          else if (tick)
            dly_cnt_r <= dly_cnt_r + 5'h01;
        end
        ST_RUN:
        begin
          // Release fires once per multiframe at the chosen point
          if (tick && mf_cnt_r == release_r)
            o_buf_release <= 1'b1;
          if (tick && mf_cnt_r != `SLRAC_DELAY_MAX)
            mf_cnt_r <= mf_cnt_r + 5'h01;
          if (glob_rise)
          begin
            dly_cnt_r <= 5'h00;
            state_r   <= ST_DELAY;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
      // Latency: ticks from delayed global edge to local edge, saturating
      if (meas_busy_r && loc_rise)
      begin
        meas_r      <= mf_cnt_r;
        meas_busy_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration checksum
  // ----------------------------------------------------------------
  reg [7:0] sum_oct;
  reg [7:0] sum_fld;
  wire [7:0] oc [0:12];
  integer    k;

  // Octet view of the received configuration words
  genvar o;
  generate
    for (o = 0; o < `SLRAC_NUM_OCT; o = o + 1)
    begin : g_oct
      assign oc[o] = i_cfg_octets[o*8 +: 8];
    end
  endgenerate

  // Both sums modulo 256; the field sum adds each packed field alone
  always @*
  begin
    sum_oct = 8'h00;
    for (k = 0; k < `SLRAC_NUM_OCT; k = k + 1)
      sum_oct = sum_oct + oc[k];
    sum_fld = oc[0] + {4'h0, oc[1][7:4]} + {4'h0, oc[1][3:0]}
            + {7'h00, oc[2][6]} + {7'h00, oc[2][5]} + {3'h0, oc[2][4:0]}
            + {7'h00, oc[3][7]} + {3'h0, oc[3][4:0]} + oc[4]
            + {3'h0, oc[5][4:0]} + oc[6] + {6'h00, oc[7][7:6]}
            + {3'h0, oc[7][4:0]} + {5'h00, oc[8][7:5]}
            + {3'h0, oc[8][4:0]} + {5'h00, oc[9][7:5]}
            + {3'h0, oc[9][4:0]} + {7'h00, oc[10][7]}
            + {3'h0, oc[10][4:0]} + oc[11] + oc[12];
  end

  // Method choice and compare, registered
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_cfg_sum     <= 8'h00;
      o_cfg_chk_err <= 1'b0;
    end
    else if (!link_en_r)
    begin
      o_cfg_sum     <= 8'h00;
      o_cfg_chk_err <= 1'b0;
    end
    else
    begin
      o_cfg_sum     <= chk_mode_r ? sum_oct : sum_fld;
      o_cfg_chk_err <= (chk_mode_r ? sum_oct : sum_fld) != i_cfg_chk;
    end
  end

  // ----------------------------------------------------------------
  // Lane crossbar
  // ----------------------------------------------------------------
  wire [11:0] src_all;
  wire [31:0] lane_nxt;
  assign src_all = {xbar_b_r, xbar_a_r};

  // Lane 2n from bits 2:0, lane 2n+1 from bits 5:3 of each pair
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_lane
      wire [2:0] src;
      assign src = src_all[g*3 +: 3];
      assign lane_nxt[g*8 +: 8] = i_phy_data[src*8 +: 8];
    end
  endgenerate

  // One register for all lanes, so each output bit has a single driver
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_lane_data <= 32'h00000000;
    else if (!link_en_r)
      o_lane_data <= 32'h00000000;
    else
      o_lane_data <= lane_nxt;
  end

endmodule

// [tb/slrac_checker.sv]
`include "slrac_consts.vh"
module slrac_checker (
  input logic         i_clk,
  input logic         i_rstn,
  input logic         i_wb_cyc,
  input logic         i_wb_stb,
  input logic         i_wb_we,
  input logic [11:0]  i_wb_adr,
  input logic [3:0]   i_wb_sel,
  input logic [31:0]  i_wb_dat,
  input logic [31:0]  o_wb_dat,
  input logic         o_wb_ack,
  input logic [103:0] i_cfg_octets,
  input logic [7:0]   i_cfg_chk,
  input logic [31:0]  o_lane_data,
  input logic [7:0]   o_cfg_sum,
  input logic         o_cfg_chk_err,
  input logic         o_link_active,
  input logic         o_buf_release
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // Bus handshake: answer next cycle, one cycle only
  property p_ack_next; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_once; o_wb_ack |=> !o_wb_ack; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  property p_ack_cause; o_wb_ack |-> $past(i_wb_cyc && i_wb_stb); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
  property p_rd_high; o_wb_ack |-> o_wb_dat[31:8] == 24'h000000; endproperty
  a_rd_high: assert property (p_rd_high) else $error("read upper bits set");
  // Bring-up bit follows a control write at once
  property p_en_wr;
    i_wb_cyc && i_wb_stb && i_wb_we && i_wb_sel[0] && !o_wb_ack
    && i_wb_adr[11:2] == `SLRAC_IDX_CTRL
    |=> o_link_active == $past(i_wb_dat[`SLRAC_CTRL_EN_BIT]);
  endproperty
  a_en_wr: assert property (p_en_wr) else $error("bring-up bit wrong");
  property p_idle_out;
    !o_link_active [*2] |-> o_lane_data == 32'h0 && o_cfg_sum == 8'h00 && !o_cfg_chk_err;
  endproperty
  a_idle_out: assert property (p_idle_out) else $error("outputs live while idle");
  property p_idle_rel; !o_link_active [*3] |-> !o_buf_release; endproperty
  a_idle_rel: assert property (p_idle_rel) else $error("release while idle");
  property p_rel_once; o_buf_release |=> !o_buf_release; endproperty
  a_rel_once: assert property (p_rel_once) else $error("release too long");
  // Settled inputs: error flag must agree with computed sum
  property p_chk_err;
    (o_link_active && $stable(i_cfg_octets) && $stable(i_cfg_chk)) [*3]
    |-> o_cfg_chk_err == (o_cfg_sum != i_cfg_chk);
  endproperty
  a_chk_err: assert property (p_chk_err) else $error("checksum flag wrong");
endmodule
bind slrac_top slrac_checker u_chk (.i_clk, .i_rstn, .i_wb_cyc, .i_wb_stb, .i_wb_we,
  .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_cfg_octets, .i_cfg_chk,
  .o_lane_data, .o_cfg_sum, .o_cfg_chk_err, .o_link_active, .o_buf_release);

// [tb/slrac_link_model.sv]
module slrac_link_model (
  output logic       o_pclk,
  output logic       o_glob,
  output logic       o_loc,
  input  logic [3:0] i_lofs
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] tick_r = 4'h0;
  initial
  begin
    o_pclk = 1'b0;
    o_glob = 1'b0;
    o_loc = 1'b0;
  end
  // Processing clock runs free, 160 ns
  always #80 o_pclk = ~o_pclk;
  // Multiframe of 16 ticks; markers move off the rising edge
  always @(negedge o_pclk)
  begin
    tick_r <= tick_r + 4'h1;
    o_glob <= tick_r < 4'h8;
    o_loc <= 4'(tick_r - i_lofs) < 4'h8;
  end
endmodule

// [tb/slrac_top_tb.sv]
`include "slrac_consts.vh"
module slrac_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic         clk = 1'b0;
  logic         rstn = 1'b0;
  logic         cyc = 1'b0;
  logic         stb = 1'b0;
  logic         we = 1'b0;
  logic [11:0]  adr = 12'h000;
  logic [3:0]   sel = 4'h0;
  logic [31:0]  wdat = 32'h0;
  logic [103:0] oct = 104'h0;
  logic [7:0]   cchk = 8'h00;
  logic [63:0]  phy = 64'hA7A6A5A4A3A2A1A0;
  logic [3:0]   lofs = 4'h4;
  logic [31:0]  rdat, lane, a, b, c;
  logic [7:0]   sum;
  logic         ack, cerr, act, rel, pclk, glob, loc;
  int           fail_count = 0;
  int           checks = 0;
  always #2.5 clk = ~clk;
  slrac_top uut (.i_clk(clk), .i_rstn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_pclk(pclk), .i_lmfc_global(glob), .i_lmfc_local(loc), .i_cfg_octets(oct),
    .i_cfg_chk(cchk), .i_phy_data(phy), .o_lane_data(lane), .o_cfg_sum(sum),
    .o_cfg_chk_err(cerr), .o_link_active(act), .o_buf_release(rel));
  slrac_link_model link (.o_pclk(pclk), .o_glob(glob), .o_loc(loc), .i_lofs(lofs));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic cycle; only the watchdog ends a wait on a stuck slave
  task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d,
                     input logic [3:0] s, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= s;
    wdat <= {24'h000000, d};
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'hF, c);
  endtask
  task automatic rd(input logic [9:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00, 4'hF, c);
    cmp(c, {24'h000000, e});
  endtask
  task automatic t_reset;
    cmp(act, 1'b0);
    rd(`SLRAC_IDX_CTRL, 8'h00);
    rd(`SLRAC_IDX_MEAS, 8'h00);
    rd(`SLRAC_IDX_FIXED, 8'h00);
    rd(`SLRAC_IDX_RELEASE, 8'h1F);
    rd(`SLRAC_IDX_XBAR_A, 8'h08);
    rd(`SLRAC_IDX_XBAR_B, 8'h1A);
    rd(10'h3FF, 8'h00);
    wr(`SLRAC_IDX_MEAS, 8'h1F);
    rd(`SLRAC_IDX_MEAS, 8'h00);
    wr(`SLRAC_IDX_FIXED, 8'hFF);
    rd(`SLRAC_IDX_FIXED, 8'h1F);
    wr(`SLRAC_IDX_FIXED, 8'h00);
    bus(1'b1, `SLRAC_IDX_RELEASE, 8'h05, 4'hE, c);
    rd(`SLRAC_IDX_RELEASE, 8'h1F);
    wr(`SLRAC_IDX_RELEASE, 8'h03);
    rd(`SLRAC_IDX_RELEASE, 8'h03);
    wr(`SLRAC_IDX_CTRL, 8'hFF);
    rd(`SLRAC_IDX_CTRL, 8'h41);
    cmp(act, 1'b1);
    cmp(lane, 32'hA3A2A1A0);
  endtask
  // Field sum of octet 0x11 is 2, octet sum is 0x11
  task automatic t_chk;
    oct <= 104'h1100;
    cchk <= 8'h02;
    wr(`SLRAC_IDX_CTRL, 8'h01);
    repeat (4) @(posedge clk);
    cmp(sum, 8'h02);
    cmp(cerr, 1'b0);
    wr(`SLRAC_IDX_CTRL, 8'h41);
    repeat (4) @(posedge clk);
    cmp(sum, 8'h11);
    cmp(cerr, 1'b1);
  endtask
  task automatic t_xbar;
    logic [2:0]  k;
    logic [31:0] e;
    for (int n = 0; n < 8; n++)
    begin
      k = n[2:0];
      for (int i = 0; i < 4; i++)
        e[8*i+:8] = 8'hA0 + {5'h00, k + i[2:0]};
      wr(`SLRAC_IDX_CTRL, 8'h00);
      wr(`SLRAC_IDX_XBAR_A, {2'b00, k + 3'h1, k});
      wr(`SLRAC_IDX_XBAR_B, {2'b00, k + 3'h3, k + 3'h2});
      cmp(lane, 32'h0);
      wr(`SLRAC_IDX_CTRL, 8'h01);
      repeat (4) @(posedge clk);
      cmp(lane, e);
    end
  endtask
  task automatic meas(input logic [3:0] o, input logic [7:0] f, output logic [31:0] m);
    wr(`SLRAC_IDX_CTRL, 8'h00);
    lofs <= o;
    wr(`SLRAC_IDX_FIXED, f);
    wr(`SLRAC_IDX_CTRL, 8'h01);
    repeat (1600) @(posedge clk);
    bus(1'b0, `SLRAC_IDX_MEAS, 8'h00, 4'hF, m);
  endtask
  // Two multiframes of 512 cycles each hold two release pulses
  task automatic relcnt(input logic [7:0] r);
    int n;
    n = 0;
    wr(`SLRAC_IDX_CTRL, 8'h00);
    wr(`SLRAC_IDX_RELEASE, r);
    wr(`SLRAC_IDX_CTRL, 8'h01);
    repeat (1200) @(posedge clk);
    @(posedge glob);
    repeat (1024)
    begin
      @(posedge clk);
      if (rel === 1'b1)
        n++;
    end
    cmp(n, 2);
  endtask
  task automatic t_delay;
    meas(4'h4, 8'h00, a);
    meas(4'h7, 8'h00, b);
    cmp(b - a, 3);
    meas(4'h7, 8'h02, a);
    // Two ticks spent in the fixed delay shorten the measure by two
    cmp(b - a, 32'd2);
    relcnt(8'h03);
    relcnt(8'h0A);
  endtask
  task automatic close_out;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #300us;
    fail_count++;
    close_out;
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_chk;
    t_xbar;
    t_delay;
    close_out;
  end
endmodule
